// *** core/muxed_local_bus_interface.sv ***
// multiplexed address/data local bus interface
`timescale 1ns/1ps
// Functional notes
// - address phase drives address bits 19..16 on upper lines
// - data phase holds upper address lines at zero
// - low sixteen lines carry address bits 15..0 in address phase
// - data phase carries 16-bit word; device drives on writes only
// - reference clock output is half the input clock frequency
// - reference clock toggles every falling input edge, 50% duty
// - data enable low only while data transfers on the bus
// - direction high for transmit, low for receive
// - write strobe low while write data valid on bus
// - upper chip select low for memory cycles inside its window
module muxed_local_bus_interface (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_mem,
    input wire logic [lbus_pkg::ADDR_W-1:0] req_addr,
    input wire logic [lbus_pkg::DATA_W-1:0] req_wdata,
    input wire logic [lbus_pkg::ADDR_W-1:0] ucs_start,
    input wire logic [lbus_pkg::ADDR_W-1:0] ucs_stop,
    output logic rsp_valid,
    output logic [lbus_pkg::DATA_W-1:0] rsp_rdata,
    output logic ref_clk,
    output logic addr_latch,
    output logic [lbus_pkg::UPPER_W-1:0] upper_addr,
    input wire logic [lbus_pkg::DATA_W-1:0] muxed_bus_in,
    output logic [lbus_pkg::DATA_W-1:0] muxed_bus_out,
    output logic muxed_bus_oe,
    output logic data_enable_n,
    output logic transceiver_direction,
    output logic wr_strobe_n,
    output logic upper_cs_n
);
    // ---------------------------------------------------------------
    // registers and their next values
    // ---------------------------------------------------------------
    lbus_pkg::bus_state_t state_q, state_d;
    logic phase_en;
    logic write_q;
    logic [lbus_pkg::ADDR_W-1:0] addr_q;
    logic [lbus_pkg::DATA_W-1:0] wdata_q;
    logic ale_q;
    logic ale_d;
    logic [lbus_pkg::UPPER_W-1:0] upper_q;
    logic [lbus_pkg::UPPER_W-1:0] upper_d;
    logic [lbus_pkg::DATA_W-1:0] bus_out_q;
    logic [lbus_pkg::DATA_W-1:0] bus_out_d;
    logic bus_oe_q;
    logic bus_oe_d;
    logic den_n_q;
    logic den_n_d;
    logic dir_q;
    logic dir_d;
    logic wr_n_q;
    logic wr_n_d;
    logic ucs_n_q;
    logic ucs_n_d;
    logic rsp_valid_q;
    logic [lbus_pkg::DATA_W-1:0] rdata_q;

    // inclusive address window compare
    function automatic logic in_window(
        input logic [lbus_pkg::ADDR_W-1:0] a,
        input logic [lbus_pkg::ADDR_W-1:0] lo,
        input logic [lbus_pkg::ADDR_W-1:0] hi
    );
        in_window = (a >= lo) && (a <= hi);
    endfunction

    ref_clk_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .ref_clk(ref_clk),
        .phase_en(phase_en)
    );

    // ---------------------------------------------------------------
    // request acceptance and cycle sequencing
    // ---------------------------------------------------------------
    // a request is taken only from idle, on a reference edge
    wire take = phase_en && (state_q == lbus_pkg::ST_IDLE) && req_valid;
    wire ucs_hit = req_mem && in_window(req_addr, ucs_start, ucs_stop);
    assign req_ready = phase_en && (state_q == lbus_pkg::ST_IDLE);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            lbus_pkg::ST_IDLE:
                if (take)
                    state_d = lbus_pkg::ST_ADDR;
            lbus_pkg::ST_ADDR:
                state_d = lbus_pkg::ST_SETUP;
            lbus_pkg::ST_SETUP:
                state_d = lbus_pkg::ST_DATA;
            lbus_pkg::ST_DATA:
                state_d = lbus_pkg::ST_HOLD;
            lbus_pkg::ST_HOLD:
                state_d = lbus_pkg::ST_IDLE;
            default:
                state_d = lbus_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= lbus_pkg::ST_IDLE;
        else if (phase_en)
            state_q <= state_d;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            write_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= lbus_pkg::DATA_IDLE;
        end
        else if (take)
        begin
            write_q <= req_write;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    // ---------------------------------------------------------------
    // next-state phase decode for the pin registers
    // ---------------------------------------------------------------
    wire in_addr = (state_d == lbus_pkg::ST_ADDR);
    wire in_setup = (state_d == lbus_pkg::ST_SETUP);
    wire in_data = (state_d == lbus_pkg::ST_DATA);
    wire in_hold = (state_d == lbus_pkg::ST_HOLD);
    wire cyc_write = take ? req_write : write_q;
    wire cyc_active = in_addr || in_setup || in_data || in_hold;
    wire [lbus_pkg::ADDR_W-1:0] cyc_addr = take ? req_addr : addr_q;

    // ---------------------------------------------------------------
    // next pin values
    // ---------------------------------------------------------------
    assign ale_d = in_addr;
    // upper lines carry address only while the latch strobe is high
    assign upper_d = in_addr ?
        cyc_addr[lbus_pkg::UPPER_LSB +: lbus_pkg::UPPER_W]
        : lbus_pkg::UPPER_IDLE;
    assign bus_out_d = in_addr ?
        cyc_addr[lbus_pkg::DATA_W-1:0]
        : wdata_q;
    // reads release the lines after the address phase
    assign bus_oe_d = in_addr || (cyc_active && write_q);
    // direction set with the address and held to the end of the cycle,
    // so the transceivers never turn while data enable is low
    assign dir_d = in_addr ? cyc_write
        : (cyc_active ? dir_q : 1'b0);
    assign den_n_d = !(in_setup || in_data);
    assign wr_n_d = !(in_data && write_q);
    assign ucs_n_d = in_addr ? !(take && ucs_hit)
        : (cyc_active ? ucs_n_q : 1'b1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ale_q <= 1'b0;
            upper_q <= lbus_pkg::UPPER_IDLE;
            bus_out_q <= lbus_pkg::DATA_IDLE;
            bus_oe_q <= 1'b0;
            den_n_q <= 1'b1;
            dir_q <= 1'b0;
            wr_n_q <= 1'b1;
            ucs_n_q <= 1'b1;
        end
        else if (phase_en)
        begin
            ale_q <= ale_d;
            upper_q <= upper_d;
            bus_out_q <= bus_out_d;
            bus_oe_q <= bus_oe_d;
            den_n_q <= den_n_d;
            dir_q <= dir_d;
            wr_n_q <= wr_n_d;
            ucs_n_q <= ucs_n_d;
        end
    end

    // ---------------------------------------------------------------
    // read capture at the close of the data phase
    // ---------------------------------------------------------------
    // data enable is still low at this edge, so the target drives the bus
    wire read_done = phase_en && (state_q == lbus_pkg::ST_DATA) && !write_q;
    // one pulse per finished cycle, reads and writes alike
    wire cyc_done = phase_en && (state_q == lbus_pkg::ST_HOLD);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= lbus_pkg::DATA_IDLE;
            rsp_valid_q <= 1'b0;
        end
        else
        begin
            if (read_done)
                rdata_q <= muxed_bus_in;
            rsp_valid_q <= cyc_done;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign addr_latch = ale_q;
    assign upper_addr = upper_q;
    assign muxed_bus_out = bus_out_q;
    assign muxed_bus_oe = bus_oe_q;
    assign data_enable_n = den_n_q;
    assign transceiver_direction = dir_q;
    assign wr_strobe_n = wr_n_q;
    assign upper_cs_n = ucs_n_q;
endmodule // muxed_local_bus_interface

// *** core/ref_clk_div.sv ***
// divide-by-two reference clock generator
`timescale 1ns/1ps
module ref_clk_div (
    input wire logic clk,
    input wire logic sys_rst,
    output logic ref_clk,
    output logic phase_en
);
    logic ref_clk_q;

    // ---------------------------------------------------------------
    // toggle on every falling clock edge, 50 percent duty
    // ---------------------------------------------------------------
    always_ff @(negedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ref_clk_q <= 1'b0;
        else
            ref_clk_q <= ~ref_clk_q;
    end

    assign ref_clk = ref_clk_q;
    // bus outputs advance once per reference period, on its rising half
    assign phase_en = ref_clk_q;
endmodule // ref_clk_div

// *** pkg/lbus_pkg.sv ***
// constants and types for the multiplexed local bus interface
package lbus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int UPPER_W = 4;
    localparam int UPPER_LSB = 16;
    localparam logic [UPPER_W-1:0] UPPER_IDLE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
    // default upper chip-select window, top 64 kbyte
    localparam logic [ADDR_W-1:0] UCS_START_RST = 20'hf0000;
    localparam logic [ADDR_W-1:0] UCS_STOP_RST = 20'hfffff;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SETUP,
        ST_DATA,
        ST_HOLD
    } bus_state_t;
endpackage

// *** verif/bus_target_model.sv ***
// memory target on the far side of the local bus
`timescale 1ns/1ps
module bus_target_model (
    input wire logic clk,
    input wire logic addr_latch,
    input wire logic [15:0] bus_out,
    input wire logic den_n,
    input wire logic dir,
    input wire logic wr_n,
    output logic [15:0] bus_in
);
    logic [15:0] mem_q [16];
    logic [3:0] idx_q;
    logic [15:0] last_q = 16'h0000;
    always_ff @(posedge clk)
    begin
        if (addr_latch)
            idx_q <= bus_out[3:0];
        if (!wr_n)
            mem_q[idx_q] <= bus_out;
        if (!den_n && !dir)
            last_q <= mem_q[idx_q];
    end
    // released bus shows the inverse of its last value
    assign bus_in = (!den_n && !dir) ? mem_q[idx_q] : ~last_q;
endmodule // bus_target_model

// *** verif/muxed_local_bus_interface_bench.sv ***
// self-checking bench for the multiplexed local bus interface
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            $display("unexpected %s exp %h got %h", n, e, g); \
            mismatches++; \
        end \
    end
module muxed_local_bus_interface_bench;
    logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic req_mem = 1'b0, req_ready, rsp_valid, ref_clk, addr_latch, cs;
    logic muxed_bus_oe, data_enable_n, transceiver_direction, wr_strobe_n;
    logic upper_cs_n;
    logic [3:0] upper_addr;
    logic [19:0] req_addr = 20'h00000, ucs_start = 20'h10000;
    logic [19:0] ucs_stop = 20'h1ffff;
    logic [15:0] req_wdata = 16'h0000, rsp_rdata, muxed_bus_in, muxed_bus_out;
    logic [15:0] q;
    int mismatches = 0, samples_checked = 0;
    muxed_local_bus_interface u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req_write(req_write),
        .req_mem(req_mem),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .ucs_start(ucs_start),
        .ucs_stop(ucs_stop),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .ref_clk(ref_clk),
        .addr_latch(addr_latch),
        .upper_addr(upper_addr),
        .muxed_bus_in(muxed_bus_in),
        .muxed_bus_out(muxed_bus_out),
        .muxed_bus_oe(muxed_bus_oe),
        .data_enable_n(data_enable_n),
        .transceiver_direction(transceiver_direction),
        .wr_strobe_n(wr_strobe_n),
        .upper_cs_n(upper_cs_n)
    );
    bus_target_model u_target (.clk(clk), .addr_latch(addr_latch),
        .bus_out(muxed_bus_out), .den_n(data_enable_n),
        .dir(transceiver_direction), .wr_n(wr_strobe_n),
        .bus_in(muxed_bus_in));
    initial
        forever #2 clk = ~clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input logic w, m, input logic [19:0] a,
        input logic [15:0] d);
        int n;
        n = 0;
        {req_write, req_mem, req_addr, req_wdata} = {w, m, a, d};
        req_valid = 1'b1;
        #2;
        while (req_ready !== 1'b1 && n < 20)
        begin
            #4;
            n++;
        end
        `CHK("ready", 1'b1, req_ready)
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        cs = !upper_cs_n;
        `CHK("latch", 1'b1, addr_latch)
        `CHK("upper", a[19:16], upper_addr)
        `CHK("low", a[15:0], muxed_bus_out)
        `CHK("dir", w, transceiver_direction)
        `CHK("den addr", 1'b1, data_enable_n)
        repeat (2) @(posedge clk);
        #1;
        `CHK("latch off", 1'b0, addr_latch)
        `CHK("upper data", 4'h0, upper_addr)
        `CHK("den data", 1'b0, data_enable_n)
        `CHK("oe", w, muxed_bus_oe)
        if (w)
            `CHK("word", d, muxed_bus_out)
        repeat (2) @(posedge clk);
        #1;
        `CHK("wr", !w, wr_strobe_n)
        `CHK("dir hold", w, transceiver_direction)
        `CHK("ucs hold", cs, !upper_cs_n)
        repeat (2) @(posedge clk);
        #1;
        `CHK("den end", 1'b1, data_enable_n)
        `CHK("wr end", 1'b1, wr_strobe_n)
        repeat (2) @(posedge clk);
        #1;
        `CHK("done", 1'b1, rsp_valid)
        `CHK("ucs end", 1'b1, upper_cs_n)
        `CHK("dir idle", 1'b0, transceiver_direction)
        q = rsp_rdata;
    endtask
    task automatic t_ref();
        logic prev;
        for (int i = 0; i < 8; i++)
        begin
            prev = ref_clk;
            @(negedge clk);
            #1;
            `CHK("ref fall", !prev, ref_clk)
            @(posedge clk);
            #1;
            `CHK("ref held", !prev, ref_clk)
        end
    endtask
    task automatic t_write_read();
        cyc(1'b1, 1'b0, 20'h12345, 16'ha5c3);
        cyc(1'b1, 1'b1, 20'hfedca, 16'h5a3c);
        cyc(1'b0, 1'b0, 20'h12345, 16'h0000);
        `CHK("rdata", 16'ha5c3, q)
        cyc(1'b0, 1'b1, 20'hfedca, 16'h0000);
        `CHK("rdata", 16'h5a3c, q)
    endtask
    task automatic t_ucs();
        logic [20:0] tbl [5] = '{21'h110000, 21'h11ffff, 21'h120000,
            21'h10ffff, 21'h018000};
        logic [4:0] hit = 5'b00011;
        for (int i = 0; i < 5; i++)
        begin
            cyc(1'b0, tbl[i][20], tbl[i][19:0], 16'h0000);
            `CHK("ucs", hit[i], cs)
        end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_ref();
        t_write_read();
        t_ucs();
        summarize();
    end
    initial
    begin
        #20000;
        mismatches++;
        summarize();
    end
endmodule // muxed_local_bus_interface_bench
bind muxed_local_bus_interface muxed_local_bus_interface_props u_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_write(req_write),
    .req_mem(req_mem),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .ucs_start(ucs_start),
    .ucs_stop(ucs_stop),
    .ref_clk(ref_clk),
    .addr_latch(addr_latch),
    .upper_addr(upper_addr),
    .muxed_bus_out(muxed_bus_out),
    .muxed_bus_oe(muxed_bus_oe),
    .data_enable_n(data_enable_n),
    .transceiver_direction(transceiver_direction),
    .wr_strobe_n(wr_strobe_n),
    .upper_cs_n(upper_cs_n)
);

// *** verif/muxed_local_bus_interface_props.sv ***
// bus timing checker for the local bus interface ports
`timescale 1ns/1ps
module muxed_local_bus_interface_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic req_mem,
    input wire logic [lbus_pkg::ADDR_W-1:0] req_addr,
    input wire logic [lbus_pkg::DATA_W-1:0] req_wdata,
    input wire logic [lbus_pkg::ADDR_W-1:0] ucs_start,
    input wire logic [lbus_pkg::ADDR_W-1:0] ucs_stop,
    input wire logic ref_clk,
    input wire logic addr_latch,
    input wire logic [lbus_pkg::UPPER_W-1:0] upper_addr,
    input wire logic [lbus_pkg::DATA_W-1:0] muxed_bus_out,
    input wire logic muxed_bus_oe,
    input wire logic data_enable_n,
    input wire logic transceiver_direction,
    input wire logic wr_strobe_n,
    input wire logic upper_cs_n
);
    wire take = req_valid && req_ready;
    wire hit = req_mem && req_addr >= ucs_start && req_addr <= ucs_stop;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_addr_phase: assert property (take |=> addr_latch &&
        upper_addr == $past(req_addr[19:16]) &&
        muxed_bus_out == $past(req_addr[15:0])) else $error("addr phase");
    a_upper_zero: assert property (!addr_latch |->
        upper_addr == 4'h0) else $error("upper lines not zero");
    a_write_word: assert property (take && req_write |-> ##3
        muxed_bus_oe && muxed_bus_out == $past(req_wdata, 3))
        else $error("write word");
    a_ref_toggle: assert property (!$past(sys_rst) |->
        ref_clk != $past(ref_clk)) else $error("ref clock");
    a_den_window: assert property (take |=> data_enable_n[*2]
        ##1 !data_enable_n[*4] ##1 data_enable_n) else $error("den");
    a_dir_code: assert property (take |=>
        transceiver_direction == $past(req_write)) else $error("dir");
    a_wr_pulse: assert property (take && req_write |=>
        wr_strobe_n[*4] ##1 !wr_strobe_n[*2] ##1 wr_strobe_n)
        else $error("write strobe");
    a_ucs_select: assert property (take |=>
        upper_cs_n == !$past(hit)) else $error("chip select");
    a_dir_steady: assert property (!data_enable_n |->
        $stable(transceiver_direction)) else $error("dir moved");
    a_read_release: assert property (take && !req_write |=>
        ##2 (!muxed_bus_oe)[*6]) else $error("read drive");
endmodule // muxed_local_bus_interface_props
